//--- adc_seq_ctrl.sv
`timescale 1ns/1ns
module adc_seq_ctrl
  import adc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // system power state
  input  wire logic        stop_mode,
  // analog core
  input  wire logic [9:0]  adc_raw,
  output logic             ana_pwr_on,
  output logic             conv_clk,
  output logic             conv_start,
  output logic      [2:0]  chan_sel,
  output logic      [7:0]  pin_analog_en,
  // completion
  output logic             conv_irq
);

  adc_state_s s_r;
  adc_state_s s_nxt;

  logic        req;
  logic        wr_acc;
  logic        active;
  logic        tick;
  logic [31:0] wword;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] ctrl_word(input adc_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ADC_CTRL_PU]    = s.pu;
    w[ADC_CTRL_CONT]  = s.cont;
    w[ADC_CTRL_RES10] = s.res10;
    w[ADC_CTRL_JH:ADC_CTRL_JL]   = s.just;
    w[ADC_CTRL_IE]    = s.ie;
    w[ADC_CTRL_CHH:ADC_CTRL_CHL] = s.chan;
    return w;
  endfunction

  function automatic logic [31:0] status_word(
    input adc_state_s s,
    input logic       act
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ADC_ST_DONE]   = s.flag;
    w[ADC_ST_BUSY]   = (s.st == ADC_CONV);
    w[ADC_ST_ACTIVE] = act;
    return w;
  endfunction

  function automatic logic [15:0] place_result(
    input logic [9:0] raw,
    input logic       res10,
    input logic [1:0] just
  );
    logic [15:0] left;
    logic [15:0] r;
    left = res10 ? {raw, 6'h00} : {raw[9:2], 8'h00};
    unique case (just)
      ADC_JUST_RIGHT:  r = res10 ? {6'h00, raw} : {8'h00, raw[9:2]};
      ADC_JUST_SIGNED: r = {~left[15], left[14:0]};
      default:         r = left;
    endcase
    return r;
  endfunction

  assign req    = avs_read | avs_write;
  assign wr_acc = avs_write & s_r.ack;
  assign wword  = merge_bytes(ctrl_word(s_r), avs_writedata, avs_byteenable);
  // stop resumes only with power-up held
  assign active = s_r.pu & ~stop_mode;
  assign tick   = active && (s_r.div == 6'(ADC_DIV_CYC - 1));

  always_comb begin
    s_nxt         = s_r;
    s_nxt.start_o = 1'b0;
    s_nxt.sync1   = adc_raw;
    s_nxt.sync2   = s_r.sync1;
    // one wait state per access
    s_nxt.ack     = req & ~s_r.ack;

    // bus served in any power state
    if (req && !s_r.ack) begin
      unique case (avs_address)
        ADC_OFF_CTRL:   s_nxt.rdata = ctrl_word(s_r);
        ADC_OFF_STATUS: s_nxt.rdata = status_word(s_r, active);
        ADC_OFF_RESULT: s_nxt.rdata = {16'h0000, s_r.result};
        ADC_OFF_PINS:   s_nxt.rdata = {24'h00_0000, s_r.pin_an};
        default:        s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    if (wr_acc) begin
      unique case (avs_address)
        ADC_OFF_CTRL: begin
          s_nxt.pu    = wword[ADC_CTRL_PU];
          s_nxt.cont  = wword[ADC_CTRL_CONT];
          s_nxt.res10 = wword[ADC_CTRL_RES10];
          s_nxt.just  = wword[ADC_CTRL_JH:ADC_CTRL_JL];
          s_nxt.ie    = wword[ADC_CTRL_IE];
          s_nxt.chan  = wword[ADC_CTRL_CHH:ADC_CTRL_CHL];
        end
        ADC_OFF_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[ADC_ST_DONE]) begin
            s_nxt.flag = 1'b0;
          end
        end
        ADC_OFF_CMD: begin
          if (avs_byteenable[0]) begin
            if (avs_writedata[ADC_CMD_HALT]) begin
              s_nxt.st = ADC_IDLE;
            end else if (avs_writedata[ADC_CMD_GO] && active) begin
              s_nxt.st      = ADC_CONV;
              s_nxt.div     = 6'h00;
              s_nxt.ticks   = 5'h00;
              s_nxt.start_o = 1'b1;
            end
          end
        end
        ADC_OFF_PINS: begin
          if (avs_byteenable[0]) begin
            s_nxt.pin_an = avs_writedata[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    if (!active) begin
      s_nxt.st      = ADC_IDLE;
      s_nxt.div     = 6'h00;
      s_nxt.ticks   = 5'h00;
      s_nxt.clk_o   = 1'b0;
      s_nxt.start_o = 1'b0;
    end else if (!s_nxt.start_o) begin
      s_nxt.div   = tick ? 6'h00 : s_r.div + 6'h01;
      s_nxt.clk_o = (s_nxt.div < 6'(ADC_DIV_CYC / 2));
      if (s_r.st == ADC_CONV && s_nxt.st == ADC_CONV && tick) begin
        if (s_r.ticks == 5'(ADC_CONV_TICKS - 1)) begin
          s_nxt.result = place_result(s_r.sync2, s_r.res10, s_r.just);
          s_nxt.flag   = 1'b1;
          s_nxt.ticks  = 5'h00;
          if (s_r.cont) begin
            s_nxt.start_o = 1'b1;
          end else begin
            s_nxt.st = ADC_IDLE;
          end
        end else begin
          s_nxt.ticks = s_r.ticks + 5'h01;
        end
      end
    end else begin
      s_nxt.clk_o = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_r        <= '0;
      s_r.pu     <= ADC_CTRL_RST[ADC_CTRL_PU];
      s_r.pin_an <= ADC_PINS_RST;
      s_r.st     <= ADC_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = req & ~s_r.ack;
  assign ana_pwr_on      = s_r.pu & ~stop_mode;
  assign conv_clk        = s_r.clk_o;
  assign conv_start      = s_r.start_o;
  assign chan_sel        = s_r.chan;
  assign pin_analog_en   = s_r.pin_an;
  assign conv_irq        = s_r.flag & s_r.ie;

endmodule

//--- adc_pkg.sv
package adc_pkg;

  // bus map (byte addresses)
  localparam logic [4:0] ADC_OFF_CTRL   = 5'h00;
  localparam logic [4:0] ADC_OFF_STATUS = 5'h04;
  localparam logic [4:0] ADC_OFF_CMD    = 5'h08;
  localparam logic [4:0] ADC_OFF_RESULT = 5'h0C;
  localparam logic [4:0] ADC_OFF_PINS   = 5'h10;

  // control register fields
  localparam int ADC_CTRL_PU    = 0;
  localparam int ADC_CTRL_CONT  = 1;
  localparam int ADC_CTRL_RES10 = 2;
  localparam int ADC_CTRL_JL    = 3;
  localparam int ADC_CTRL_JH    = 4;
  localparam int ADC_CTRL_IE    = 5;
  localparam int ADC_CTRL_CHL   = 8;
  localparam int ADC_CTRL_CHH   = 10;

  // status register fields
  localparam int ADC_ST_DONE   = 0;
  localparam int ADC_ST_BUSY   = 1;
  localparam int ADC_ST_ACTIVE = 2;

  // command register fields
  localparam int ADC_CMD_GO   = 0;
  localparam int ADC_CMD_HALT = 1;

  // result placement codes
  localparam logic [1:0] ADC_JUST_LEFT   = 2'h0;
  localparam logic [1:0] ADC_JUST_SIGNED = 2'h1;
  localparam logic [1:0] ADC_JUST_RIGHT  = 2'h2;

  // reset values
  localparam logic [31:0] ADC_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0]  ADC_PINS_RST = 8'h00;

  // timing
  localparam int ADC_CLK_HZ       = 100_000_000;
  localparam int ADC_CONV_HZ      = 2_000_000;
  localparam int ADC_CONV_TIME_NS = 14_000;
  localparam int ADC_DIV_CYC      = ADC_CLK_HZ / ADC_CONV_HZ;
  localparam int ADC_CONV_TICKS   =
    ADC_CONV_TIME_NS / (1_000_000_000 / ADC_CONV_HZ);

  typedef enum logic [0:0] {
    ADC_IDLE,
    ADC_CONV
  } adc_state_e;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        pu;
    logic        cont;
    logic        res10;
    logic [1:0]  just;
    logic        ie;
    logic [2:0]  chan;
    logic [7:0]  pin_an;
    logic        flag;
    logic [15:0] result;
    adc_state_e  st;
    logic [5:0]  div;
    logic [4:0]  ticks;
    logic        clk_o;
    logic        start_o;
    logic [9:0]  sync1;
    logic [9:0]  sync2;
  } adc_state_s;

endpackage

//--- adc_seq_ctrl_sva.sv
`timescale 1ns/1ns
module adc_seq_ctrl_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bus and power
  input wire logic avs_waitrequest,
  input wire logic stop_mode,
  // converter
  input wire logic ana_pwr_on,
  input wire logic conv_clk,
  input wire logic conv_start,
  input wire logic conv_irq
);
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // cycles since the last conversion start, saturating
  always_comb cnt_nxt = conv_start ? 11'h001 : cnt_r + {10'h000, ~&cnt_r};
  always_ff @(posedge clk_sys) cnt_r <= rstn ? cnt_nxt : 11'h7FF;
  a_stop_pwr_off: assert property (stop_mode |-> !ana_pwr_on)
    else $error("analog power on in stop");
  a_stop_clk_low: assert property (stop_mode [*2] |-> !conv_clk)
    else $error("conversion clock runs in stop");
  a_stop_no_start: assert property (stop_mode [*2] |-> !conv_start)
    else $error("conversion started in stop");
  a_off_clk_low: assert property ((!ana_pwr_on) [*2] |-> !conv_clk)
    else $error("conversion clock runs powered down");
  a_start_when_on: assert property (conv_start |-> $past(ana_pwr_on))
    else $error("conversion started while off");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_done_time: assert property ($rose(conv_irq) |-> cnt_r == 11'h578)
    else $error("conversion time wrong");
  a_wait_once: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait too long");
  c_done: cover property ($rose(conv_irq));
  c_stop_busy: cover property (conv_start ##[1:300] stop_mode);
  c_pwr_off: cover property ($fell(ana_pwr_on));
endmodule
bind adc_seq_ctrl adc_seq_ctrl_sva i_sva (.clk_sys, .rstn, .avs_waitrequest,
  .stop_mode, .ana_pwr_on, .conv_clk, .conv_start, .conv_irq);

//--- adc_ana_src.sv
`timescale 1ns/1ns
module adc_ana_src (
  // clock
  input  wire logic       clk_sys,
  // converter side
  input  wire logic       ana_pwr_on,
  input  wire logic [2:0] chan_sel,
  output logic      [9:0] adc_raw
);
  initial adc_raw = 10'h155;
  // unpowered source wanders every cycle
  always @(posedge clk_sys) begin
    adc_raw <= ana_pwr_on ? {chan_sel, 7'h2B} : ~adc_raw;
  end
endmodule

//--- test_adc_seq_ctrl.sv
`timescale 1ns/1ns
module test_adc_seq_ctrl
  import adc_pkg::*;
;
  logic        clk_sys = 1'b0, rstn = 1'b0, avs_read = 1'b0;
  logic        avs_write = 1'b0, stop_mode = 1'b0, avs_waitrequest;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [9:0]  adc_raw;
  logic        ana_pwr_on, conv_clk, conv_start, conv_irq;
  logic [2:0]  chan_sel;
  logic [7:0]  pin_analog_en;
  int          num_errors = 0, checked = 0, starts;
  bit          irq_seen;
  logic [5:0]  f [4] = '{6'h25, 6'h2D, 6'h35, 6'h31};
  always #5 clk_sys = ~clk_sys;
  adc_seq_ctrl i_dut (.*, .avs_byteenable(4'hF));
  adc_ana_src i_src (.*);
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    logic wt;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    // waitrequest taken mid-cycle, so the edge after it is the accepting one
    do begin
      @(negedge clk_sys);
      wt = avs_waitrequest;
      @(posedge clk_sys);
      n++;
    end while (wt !== 1'b0 && n < 50);
    if (wt !== 1'b0) begin
      num_errors++;
      complete_run;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task run(input int n, input bit to_irq);
    starts = 0;
    irq_seen = 0;
    repeat (n) begin
      @(posedge clk_sys);
      @(negedge clk_sys);
      starts += int'(conv_start === 1'b1);
      if (conv_irq === 1'b1) irq_seen = 1;
      if (to_irq && irq_seen) break;
    end
    @(posedge clk_sys);
    if (to_irq && !irq_seen) begin
      num_errors++;
      complete_run;
    end
  endtask
  function logic [15:0] ex(input logic [5:0] c, input logic [9:0] v);
    logic [15:0] l;
    l = c[2] ? {v, 6'h00} : {v[9:2], 8'h00};
    if (c[4:3] == ADC_JUST_RIGHT) return c[2] ? {6'h00, v} : {8'h00, v[9:2]};
    return c[4:3] == ADC_JUST_SIGNED ? {~l[15], l[14:0]} : l;
  endfunction
  task t_idle;
    acc(1'b0, ADC_OFF_CTRL, 32'h0);
    chk("ctrl", ADC_CTRL_RST, rd);
    chk("power", 32'h0, {31'h0, ana_pwr_on});
    acc(1'b1, ADC_OFF_PINS, 32'hA5);
    acc(1'b0, ADC_OFF_PINS, 32'h0);
    chk("pins rd", 32'hA5, rd);
    chk("pins", 32'hA5, {24'h0, pin_analog_en});
  endtask
  task t_conv;
    foreach (f[i]) begin
      acc(1'b1, ADC_OFF_CTRL, {21'h0, 3'h5, 2'h0, f[i]});
      acc(1'b1, ADC_OFF_STATUS, 32'h1);
      acc(1'b1, ADC_OFF_CMD, 32'h1);
      run(2000, 1'b1);
      acc(1'b0, ADC_OFF_RESULT, 32'h0);
      chk("result", {16'h0, ex(f[i], {3'h5, 7'h2B})}, rd);
    end
    chk("chan", 32'h5, {29'h0, chan_sel});
  endtask
  task t_pdown;
    acc(1'b1, ADC_OFF_STATUS, 32'h1);
    acc(1'b1, ADC_OFF_CMD, 32'h1);
    run(100, 1'b0);
    acc(1'b1, ADC_OFF_CTRL, 32'h0524);
    run(1500, 1'b0);
    acc(1'b0, ADC_OFF_STATUS, 32'h0);
    chk("pd status", 32'h0, rd | {31'h0, irq_seen});
    acc(1'b1, ADC_OFF_CTRL, 32'h0525);
    acc(1'b0, ADC_OFF_STATUS, 32'h0);
    chk("pu status", 32'h4, rd);
  endtask
  task t_stop;
    acc(1'b1, ADC_OFF_CMD, 32'h1);
    run(100, 1'b0);
    stop_mode <= 1'b1;
    run(50, 1'b0);
    stop_mode <= 1'b0;
    run(1500, 1'b0);
    chk("stop starts", 32'h0, starts);
    acc(1'b0, ADC_OFF_STATUS, 32'h0);
    chk("stop status", 32'h4, rd | {31'h0, irq_seen});
    acc(1'b0, ADC_OFF_CTRL, 32'h0);
    chk("stop ctrl", 32'h0525, rd);
  endtask
  task t_cont;
    acc(1'b1, ADC_OFF_CTRL, 32'h0507);
    acc(1'b1, ADC_OFF_CMD, 32'h1);
    run(2000, 1'b0);
    chk("cont starts", 32'h1, starts);
    acc(1'b1, ADC_OFF_CMD, 32'h2);
    run(1500, 1'b0);
    chk("halt starts", 32'h0, starts);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_idle;
    t_conv;
    t_pdown;
    t_stop;
    t_cont;
    complete_run;
  end
endmodule
